// ---- dv/test_radio_power_enable_sequencer.sv ----
// Self-checking bench for the radio power enable sequencer.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module test_radio_power_enable_sequencer;
  localparam int POR = 20;
  localparam int DIS = 8;
  localparam int SOF = 10;
  logic        ref_clk_i = 1'b0;
  logic        rst_b = 1'b0;
  logic        wlan_en = 1'b0;
  logic        radio_en = 1'b0;
  logic        host_start = 1'b0;
  logic        usb_rst;
  logic        usb_sof;
  logic        reg_en;
  logic        wl_rst_b;
  logic        rd_rst_b;
  logic        por_done;
  logic        usb_ready;
  logic        dis_ok;
  logic        short_gap;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          i;
  int          k;
  int          cnt;
  logic [31:0] seed = 32'd38972;
  logic [31:0] x;

  always #25 ref_clk_i = ~ref_clk_i;

  radio_power_enable_sequencer #(.POR_CYCLES(POR), .DISCHARGE_CYCLES(DIS),
    .WARM_BOOT_CYCLES(16), .SOF_CYCLES(SOF)) dut_u (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b), .wlan_power_enable_i(wlan_en), .radio_power_enable_i(radio_en),
    .usb_bus_reset_i(usb_rst), .usb_sof_i(usb_sof), .regulator_enable_o(reg_en),
    .wlan_reset_b_o(wl_rst_b), .radio_reset_b_o(rd_rst_b), .por_done_o(por_done),
    .usb_ready_o(usb_ready), .discharge_ok_o(dis_ok), .short_off_gap_o(short_gap));

  usb_host_model host_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b), .start_i(host_start),
    .usb_bus_reset_o(usb_rst), .usb_sof_o(usb_sof));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic test_done();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // Drives a new pin pair and checks the regulator before and all three outputs after the sync delay.
  task automatic apply(input logic w, input logic r);
    logic pv;
    pv = wlan_en | radio_en;
    @(posedge ref_clk_i);
    wlan_en  <= w;
    radio_en <= r;
    @(posedge ref_clk_i);
    #1;
    `CHK(reg_en, pv)
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK(reg_en, w | r)
    `CHK(wl_rst_b, w)
    `CHK(rd_rst_b, r)
  endtask : apply

  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rst_b   <= 1'b1;
    wlan_en <= 1'b1;
    repeat (POR - 2) @(posedge ref_clk_i);
    #1;
    `CHK(por_done, 1'b0)
    `CHK(wl_rst_b, 1'b0)
    repeat (4) @(posedge ref_clk_i);
    #1;
    `CHK(por_done, 1'b1)
    `CHK(wl_rst_b, 1'b1)
    $display("test power-on reset done");
    for (i = 0; i < 40; i++)
    begin
      x = xs();
      apply(x[0], x[1]);
      repeat (x[4:2]) @(posedge ref_clk_i);
    end
    $display("test random enables done");
    apply(1'b1, 1'b0);
    apply(1'b0, 1'b0);
    @(posedge ref_clk_i);
    #1;
    `CHK(dis_ok, 1'b0)
    apply(1'b1, 1'b0);
    `CHK(short_gap, 1'b1)
    apply(1'b0, 1'b0);
    repeat (DIS + 12) @(posedge ref_clk_i);
    #1;
    `CHK(dis_ok, 1'b1)
    apply(1'b1, 1'b0);
    `CHK(short_gap, 1'b0)
    $display("test discharge gap done");
    apply(1'b0, 1'b1);
    repeat (30) @(posedge ref_clk_i);
    // The second pass restarts the host while ready, so a bus reset leaves the ready state.
    for (k = 0; k < 2; k++)
    begin
      host_start <= 1'b1;
      for (i = 0; i < 100 && usb_sof !== 1'b1; i++)
      begin
        @(posedge ref_clk_i);
        #1;
      end
      `CHK(i < 100, 1'b1)
      `CHK(usb_ready, 1'b0)
      cnt = 0;
      for (i = 0; i < 100 && usb_ready !== 1'b1; i++)
      begin
        @(posedge ref_clk_i);
        #1;
        cnt++;
      end
      `CHK(cnt, SOF + 1)
      @(posedge ref_clk_i);
      host_start <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
    apply(1'b0, 1'b0);
    @(posedge ref_clk_i);
    #1;
    `CHK(usb_ready, 1'b0)
    $display("test usb readiness done");
    test_done();
  end
endmodule : test_radio_power_enable_sequencer

// ---- dv/usb_host_model.sv ----
// Behavioural host that drives the USB bus reset and the frame starts.
`timescale 1ns/10ps

module usb_host_model
#(
  parameter int RST_CYC = 12,
  parameter int SOF_GAP = 3
)
(
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic start_i,
  output      logic usb_bus_reset_o,
  output      logic usb_sof_o
);
  int cnt;

  // Start is raised only after the attach debounce wait of the bench.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      cnt <= 0;
    else
      cnt <= start_i ? cnt + 1 : 0;

  assign usb_bus_reset_o = start_i && (cnt < RST_CYC);
  assign usb_sof_o       = start_i && (cnt > RST_CYC + 1) && (cnt % SOF_GAP == 0);
endmodule : usb_host_model

// ---- inc/radio_power_params.svh ----
// Timing and reset constants for the radio power enable sequencer.
`ifndef RADIO_POWER_PARAMS_SVH
`define RADIO_POWER_PARAMS_SVH

`define CLK_FREQ_HZ        64'd20000000
`define MS_PER_S           64'd1000
`define POR_MAX_MS         64'd110
`define DISCHARGE_MIN_MS   64'd10
`define WARM_BOOT_MIN_MS   64'd100
`define SOF_MIN_MS         64'd10
`define POR_CYCLES         (`POR_MAX_MS * `CLK_FREQ_HZ / `MS_PER_S)
`define DISCHARGE_CYCLES   ((`DISCHARGE_MIN_MS * `CLK_FREQ_HZ + `MS_PER_S - 64'd1) / `MS_PER_S)
`define WARM_BOOT_CYCLES   ((`WARM_BOOT_MIN_MS * `CLK_FREQ_HZ + `MS_PER_S - 64'd1) / `MS_PER_S)
`define SOF_CYCLES         ((`SOF_MIN_MS * `CLK_FREQ_HZ + `MS_PER_S - 64'd1) / `MS_PER_S)
`define CNT_W              22
`define SYNC_RESET_VAL     2'h0

`endif

// ---- inc/radio_power_pkg.sv ----
// Types shared by the radio power enable sequencer files.
package radio_power_pkg;

  typedef struct packed {
    logic wlan_power_enable;
    logic radio_power_enable;
  } enable_pair_type;

  typedef enum logic [2:0] {
    USB_OFF,
    USB_DETACHED,
    USB_BUS_RESET,
    USB_WAIT_SOF,
    USB_SOF,
    USB_READY
  } usb_state_type;

endpackage : radio_power_pkg

// ---- rtl/enable_sync.sv ----
// Two flip-flop synchroniser for the pair of power enable pins.
`timescale 1ns/10ps
`include "radio_power_params.svh"

module enable_sync
(
  input  wire logic                            ref_clk_i,
  input  wire logic                            rst_b_i,
  input  wire radio_power_pkg::enable_pair_type pins_i,
  output      radio_power_pkg::enable_pair_type sync_o
);
  import radio_power_pkg::*;

  logic [1:0] raw;
  logic [1:0] stage1_reg;
  logic [1:0] stage2_reg;

  assign raw    = pins_i;
  assign sync_o = stage2_reg;

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_bit
      always_ff @(posedge ref_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          stage1_reg[i] <= 1'b0;
          stage2_reg[i] <= 1'b0;
        end
        else
        begin
          stage1_reg[i] <= raw[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

endmodule : enable_sync

// ---- rtl/radio_power_enable_sequencer.sv ----
// Power, reset and USB readiness sequencing for the wireless and radio sections.
`timescale 1ns/10ps
`include "radio_power_params.svh"

// Overview of operation
// RULE1: Regulators on while either enable is high.
// RULE2: Wlan section released while wlan enable high.
// RULE3: Wlan section held in reset while wlan low.
// RULE4: Radio held in reset while radio enable low.
// RULE5: Host keeps both enables low ten milliseconds.
// RULE6: Power-on reset releases within 110 milliseconds.
// RULE7: Host warm boot gap 100, cold 10 ms.
// RULE8: Host delays are minimums; longer ones accepted.
// RULE9: Host debounces USB attach over 100 ms.
// RULE10: Host drives USB bus reset over 10 ms.
// RULE11: Host sends frame starts over 10 ms.
// RULE12: Device ready for USB after frame-start period.
// RULE13: Enable pins synchronised before driving resets.
module radio_power_enable_sequencer
#(
  parameter int unsigned POR_CYCLES       = 32'(`POR_CYCLES),
  parameter int unsigned DISCHARGE_CYCLES = 32'(`DISCHARGE_CYCLES),
  parameter int unsigned WARM_BOOT_CYCLES = 32'(`WARM_BOOT_CYCLES),
  parameter int unsigned SOF_CYCLES       = 32'(`SOF_CYCLES)
)
(
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic wlan_power_enable_i,
  input  wire logic radio_power_enable_i,
  input  wire logic usb_bus_reset_i,
  input  wire logic usb_sof_i,
  output      logic regulator_enable_o,
  output      logic wlan_reset_b_o,
  output      logic radio_reset_b_o,
  output      logic por_done_o,
  output      logic usb_ready_o,
  output      logic discharge_ok_o,
  output      logic short_off_gap_o
);
  import radio_power_pkg::*;

  enable_pair_type              en_pins;
  enable_pair_type              en_sync;
  logic                         any_enable;
  logic [`CNT_W-1:0]            por_count_reg;
  logic [`CNT_W-1:0]            off_count_reg;
  logic [`CNT_W-1:0]            sof_count_reg;
  logic                         any_enable_reg;
  usb_state_type                usb_state_reg;
  usb_state_type                usb_state_next;

  assign en_pins    = {wlan_power_enable_i, radio_power_enable_i};
  assign any_enable = en_sync.wlan_power_enable | en_sync.radio_power_enable;

  // Both enable pins pass two flip-flops before use. [RULE13]
  enable_sync u_enable_sync
  (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pins_i    (en_pins),
    .sync_o    (en_sync)
  );

  // Internal power-on reset counter. [RULE6]
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      por_count_reg <= '0;
      por_done_o    <= 1'b0;
    end
    else if (!por_done_o)
    begin
      por_count_reg <= por_count_reg + `CNT_W'(1);
      por_done_o    <= (por_count_reg == `CNT_W'(POR_CYCLES - 1));
    end
  end

  // Regulators follow the OR of both enables. [RULE1]
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      regulator_enable_o <= 1'b0;
    else
      regulator_enable_o <= any_enable;
  end

  // Section resets follow their own enables once power-on reset is done.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wlan_reset_b_o  <= 1'b0;
      radio_reset_b_o <= 1'b0;
    end
    else
    begin
      wlan_reset_b_o  <= por_done_o & en_sync.wlan_power_enable;   // [RULE2] [RULE3]
      radio_reset_b_o <= por_done_o & en_sync.radio_power_enable;  // [RULE4]
    end
  end

  // Measures the time both enables stay low, saturating at the warm boot gap.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      off_count_reg <= '0;
    else if (any_enable)
      off_count_reg <= '0;
    else if (off_count_reg != `CNT_W'(WARM_BOOT_CYCLES))
      off_count_reg <= off_count_reg + `CNT_W'(1);
  end

  // Reports whether the regulator has had time to discharge. [RULE5]
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      any_enable_reg  <= 1'b0;
      discharge_ok_o  <= 1'b1;
      short_off_gap_o <= 1'b0;
    end
    else
    begin
      any_enable_reg <= any_enable;
      discharge_ok_o <= any_enable | (off_count_reg >= `CNT_W'(DISCHARGE_CYCLES - 1));
      if (any_enable && !any_enable_reg && off_count_reg != '0)
        short_off_gap_o <= (off_count_reg < `CNT_W'(DISCHARGE_CYCLES));  // [RULE5] [RULE8]
    end
  end

  // Next state of the USB attach sequence seen by the radio section.
  always_comb
  begin
    usb_state_next = usb_state_reg;
    if (!radio_reset_b_o)
      usb_state_next = USB_OFF;
    else
    begin
      unique case (usb_state_reg)
        USB_OFF:
          usb_state_next = USB_DETACHED;
        USB_DETACHED:
          if (usb_bus_reset_i)
            usb_state_next = USB_BUS_RESET;  // [RULE9] [RULE10]
        USB_BUS_RESET:
          if (!usb_bus_reset_i)
            usb_state_next = USB_WAIT_SOF;
        USB_WAIT_SOF:
          if (usb_bus_reset_i)
            usb_state_next = USB_BUS_RESET;
          else if (usb_sof_i)
            usb_state_next = USB_SOF;
        USB_SOF:
          if (usb_bus_reset_i)
            usb_state_next = USB_BUS_RESET;
          else if (sof_count_reg == `CNT_W'(SOF_CYCLES - 1))
            usb_state_next = USB_READY;  // [RULE11] [RULE12]
        USB_READY:
          if (usb_bus_reset_i)
            usb_state_next = USB_BUS_RESET;
        default:
          usb_state_next = USB_OFF;
      endcase
    end
  end

  // USB state register and frame-start period counter.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      usb_state_reg <= USB_OFF;
      sof_count_reg <= '0;
    end
    else
    begin
      usb_state_reg <= usb_state_next;
      if (usb_state_reg == USB_SOF && usb_state_next == USB_SOF)
        sof_count_reg <= sof_count_reg + `CNT_W'(1);
      else
        sof_count_reg <= '0;
    end
  end

  // Readiness flag for traffic over USB. [RULE12]
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      usb_ready_o <= 1'b0;
    else
      usb_ready_o <= (usb_state_next == USB_READY);
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_regulator_on;
    any_enable |=> regulator_enable_o;
  endproperty
  a_regulator_on: assert property (p_regulator_on)  // [RULE1]
    else $error("Regulator not enabled after an enable rose.");

  property p_regulator_off;
    (!en_sync.wlan_power_enable && !en_sync.radio_power_enable) |=> !regulator_enable_o;
  endproperty
  a_regulator_off: assert property (p_regulator_off)  // [RULE1]
    else $error("Regulator enabled while both enables are low.");

  property p_wlan_release;
    (por_done_o && en_sync.wlan_power_enable) |=> wlan_reset_b_o;
  endproperty
  a_wlan_release: assert property (p_wlan_release)  // [RULE2]
    else $error("Wlan section not released while enabled.");

  property p_wlan_hold;
    !en_sync.wlan_power_enable |=> !wlan_reset_b_o;
  endproperty
  a_wlan_hold: assert property (p_wlan_hold)  // [RULE3]
    else $error("Wlan section released while its enable is low.");

  property p_radio_hold;
    (en_sync.wlan_power_enable && !en_sync.radio_power_enable) |=> !radio_reset_b_o;
  endproperty
  a_radio_hold: assert property (p_radio_hold)  // [RULE4]
    else $error("Radio section released while its enable is low.");

  property p_por_release;
    (por_count_reg == `CNT_W'(POR_CYCLES - 1)) && !por_done_o |=> por_done_o [*3];
  endproperty
  a_por_release: assert property (p_por_release)  // [RULE6]
    else $error("Power-on reset not released at its count.");

  property p_usb_ready;
    (usb_state_reg == USB_SOF && sof_count_reg == `CNT_W'(SOF_CYCLES - 1)
     && !usb_bus_reset_i && radio_reset_b_o) |=> usb_ready_o;
  endproperty
  a_usb_ready: assert property (p_usb_ready)  // [RULE12]
    else $error("USB not ready after the frame-start period.");

  property p_usb_ready_needs_radio;
    usb_ready_o |-> (usb_state_reg == USB_READY) && $past(radio_reset_b_o);
  endproperty
  a_usb_ready_needs_radio: assert property (p_usb_ready_needs_radio)  // [RULE12]
    else $error("USB ready while the radio section is in reset.");

  property p_pin_sync_delay;
    $changed(en_pins) |=> $stable(regulator_enable_o);
  endproperty
  a_pin_sync_delay: assert property (p_pin_sync_delay)  // [RULE13]
    else $error("Regulator enable reacted to an unsynchronised pin.");

  c_cold_start: cover property ($rose(wlan_reset_b_o) && regulator_enable_o);
  c_radio_only: cover property (radio_reset_b_o && !wlan_reset_b_o);
  c_usb_ready: cover property ($rose(usb_ready_o));
  c_short_gap: cover property ($rose(short_off_gap_o));

endmodule : radio_power_enable_sequencer
